// ---- logic_cell_config_regs.sv ----
// Register bank and datapath of one configurable logic cell on an Avalon-MM slave.
//
// Contract
// - Enable bit 7 lets the cell work; clear forces the cell output low.
// - Control bit 6 connects the cell result to its pin driver.
// - Control bit 5 reads the final cell output; writes ignored.
// - Rise enable bit 4 sets the interrupt flag on each output rise.
// - Fall enable bit 3 sets the interrupt flag on each output fall.
// - Codes 000 to 011: AND-OR, OR-XOR, four-input AND, set-reset latch.
// - Code 100 D flop with set and reset; 101 two-input D flop with reset.
// - Code 110 J-K flop with reset; 111 transparent latch with set, reset.
// - Polarity bit 7 inverts the function result into the cell output.
// - Polarity bits 0 to 3 invert gates 1 to 4 before the function.
// - Polarity bits 6 to 4 read zero and ignore writes.
// - Data 1 takes source code, sources 0 to 7.
// - Data 2 takes source code plus 4, sources 4 to 11.
// - Data 3 takes source code plus 8, sources 8 to 15.
// - Data 4 takes sources 12 to 15, then 0 to 3.
// - Bits 7 and 3 of both select registers read zero.
// - Control and result invert clear on reset; selections keep their value.
// - Each gate ANDs its enabled inputs; none enabled gives zero before inversion.
// - A result invert change raises an edge like any other transition.
`timescale 1ns/10ps
module logic_cell_config_regs (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [15:0] srcIn,
	output logic             cellOut,
	output logic             pinOut,
	output logic             pinOe,
	output logic             irqFlag
);
	// Control register fields, cleared by every reset.
	logic        enable_r;
	logic        pinOe_r;
	logic        riseEn_r;
	logic        fallEn_r;
	logic [2:0]  mode_r;
	logic        resInv_r;
	// Selection fields, kept across reset.
	logic [3:0]  gateInv_r;
	logic [2:0]  d1Sel_r;
	logic [2:0]  d2Sel_r;
	logic [2:0]  d3Sel_r;
	logic [2:0]  d4Sel_r;
	logic [7:0]  gateSel_r [4];
	// Bus slave state.
	logic        waitReq_r;
	logic [31:0] readData_r;
	logic        wrTake;
	logic        byteLow;
	logic [7:0]  rdMux;
	// Cell datapath.
	logic        cellOut_r;
	logic        pinOut_r;
	logic        pinOeOut_r;
	logic        prevOut_r;
	logic        irqFlag_r;
	logic        state_r;
	logic        clkPrev_r;
	logic        clkRise;
	logic        funcComb;
	logic        cellNxt;
	logic        edgeHit;
	logic        flagClr;
	logic [3:0]  g;
	logic [3:0]  d1Idx;
	logic [3:0]  d2Idx;
	logic [3:0]  d3Idx;
	logic [3:0]  d4Idx;
	cell_cfg_pkg::cell_func_t mode;

	cell_path_if path ();

	input_sync uSync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.rawIn   (srcIn),
		.path    (path.sync)
	);

	// One data gate per logic function input.
	for (genvar n = 0; n < cell_cfg_pkg::GATE_N; n++) begin : gGate
		data_gate #(.IDX(n)) uGate (
			.path (path.gate)
		);
	end

	// Source pool indices wrap in four bits, which gives data 4 its split range.
	assign d1Idx = cell_cfg_pkg::D1_BASE + {1'b0, d1Sel_r};
	assign d2Idx = cell_cfg_pkg::D2_BASE + {1'b0, d2Sel_r};
	assign d3Idx = cell_cfg_pkg::D3_BASE + {1'b0, d3Sel_r};
	assign d4Idx = cell_cfg_pkg::D4_BASE + {1'b0, d4Sel_r};

	// Selected data and gate configuration go out to the gates.
	assign path.dataIn[0] = path.srcSync[d1Idx];
	assign path.dataIn[1] = path.srcSync[d2Idx];
	assign path.dataIn[2] = path.srcSync[d3Idx];
	assign path.dataIn[3] = path.srcSync[d4Idx];
	assign path.gateSel   = gateSel_r;
	assign path.gateInv   = gateInv_r;
	assign g              = path.gateOut;

	assign mode = cell_cfg_pkg::cell_func_t'(mode_r);

	// Gate 1 clocks the flop modes; its edge is seen in the system clock.
	assign clkRise = g[0] & ~clkPrev_r;

	// Write takes effect on the edge that completes the transfer.
	assign byteLow = byteenable[0];
	assign wrTake  = write & ~waitReq_r & byteLow;

	// Bus slave: one wait cycle, then the answer stands for one edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitReq_r <= 1'b1;
		end else if ((read | write) & waitReq_r) begin
			waitReq_r <= 1'b0;
		end else begin
			waitReq_r <= 1'b1;
		end
	end

	// Read mux; unmapped offsets and unimplemented bits read zero.
	always_comb begin
		rdMux = 8'h00;
		case (address)
			cell_cfg_pkg::OFS_CONTROL: begin
				rdMux[cell_cfg_pkg::BIT_ENABLE]  = enable_r;
				rdMux[cell_cfg_pkg::BIT_PIN_OE]  = pinOe_r;
				rdMux[cell_cfg_pkg::BIT_VIEW]    = cellOut_r;
				rdMux[cell_cfg_pkg::BIT_RISE_EN] = riseEn_r;
				rdMux[cell_cfg_pkg::BIT_FALL_EN] = fallEn_r;
				rdMux[cell_cfg_pkg::MODE_LSB +: 3] = mode_r;
			end
			cell_cfg_pkg::OFS_POLARITY: begin
				rdMux[cell_cfg_pkg::BIT_RES_INV] = resInv_r;
				rdMux[cell_cfg_pkg::GINV_LSB +: 4] = gateInv_r;
			end
			cell_cfg_pkg::OFS_SEL_LOW: begin
				rdMux[cell_cfg_pkg::SEL_LO_LSB +: 3] = d1Sel_r;
				rdMux[cell_cfg_pkg::SEL_HI_LSB +: 3] = d2Sel_r;
			end
			cell_cfg_pkg::OFS_SEL_HIGH: begin
				rdMux[cell_cfg_pkg::SEL_LO_LSB +: 3] = d3Sel_r;
				rdMux[cell_cfg_pkg::SEL_HI_LSB +: 3] = d4Sel_r;
			end
			cell_cfg_pkg::OFS_STATUS: begin
				rdMux[cell_cfg_pkg::BIT_IRQ_FLAG] = irqFlag_r;
			end
			default: begin
				if (address[5:4] == cell_cfg_pkg::OFS_GATE_BASE[5:4]) begin
					rdMux = gateSel_r[address[3:2]];
				end
			end
		endcase
	end

	// Read data is caught on the edge that lowers waitrequest.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			readData_r <= 32'h00000000;
		end else if (read & waitReq_r) begin
			readData_r <= {24'h000000, rdMux};
		end
	end

	// Control fields clear on every reset.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_r <= cell_cfg_pkg::CONTROL_RST[cell_cfg_pkg::BIT_ENABLE];
			pinOe_r  <= cell_cfg_pkg::CONTROL_RST[cell_cfg_pkg::BIT_PIN_OE];
			riseEn_r <= cell_cfg_pkg::CONTROL_RST[cell_cfg_pkg::BIT_RISE_EN];
			fallEn_r <= cell_cfg_pkg::CONTROL_RST[cell_cfg_pkg::BIT_FALL_EN];
			mode_r   <= cell_cfg_pkg::CONTROL_RST[cell_cfg_pkg::MODE_LSB +: 3];
		end else if (wrTake && address == cell_cfg_pkg::OFS_CONTROL) begin
			enable_r <= writedata[cell_cfg_pkg::BIT_ENABLE];
			pinOe_r  <= writedata[cell_cfg_pkg::BIT_PIN_OE];
			riseEn_r <= writedata[cell_cfg_pkg::BIT_RISE_EN];
			fallEn_r <= writedata[cell_cfg_pkg::BIT_FALL_EN];
			mode_r   <= writedata[cell_cfg_pkg::MODE_LSB +: 3];
		end
	end

	// Result invert lives in the polarity register but clears like control.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			resInv_r <= cell_cfg_pkg::RES_INV_RST;
		end else if (wrTake && address == cell_cfg_pkg::OFS_POLARITY) begin
			resInv_r <= writedata[cell_cfg_pkg::BIT_RES_INV];
		end
	end

	// Selections have no reset, so they come up unknown and survive resets.
	always_ff @(posedge sys_clk) begin
		if (wrTake) begin
			case (address)
				cell_cfg_pkg::OFS_POLARITY: begin
					gateInv_r <= writedata[cell_cfg_pkg::GINV_LSB +: 4];
				end
				cell_cfg_pkg::OFS_SEL_LOW: begin
					d1Sel_r <= writedata[cell_cfg_pkg::SEL_LO_LSB +: 3];
					d2Sel_r <= writedata[cell_cfg_pkg::SEL_HI_LSB +: 3];
				end
				cell_cfg_pkg::OFS_SEL_HIGH: begin
					d3Sel_r <= writedata[cell_cfg_pkg::SEL_LO_LSB +: 3];
					d4Sel_r <= writedata[cell_cfg_pkg::SEL_HI_LSB +: 3];
				end
				default: begin
					if (address[5:4] == cell_cfg_pkg::OFS_GATE_BASE[5:4]) begin
						gateSel_r[address[3:2]] <= writedata[7:0];
					end
				end
			endcase
		end
	end

	// Combinational functions; the stored modes present their state bit.
	always_comb begin
		funcComb = 1'b0;
		case (mode)
			cell_cfg_pkg::FN_AND_OR: begin
				funcComb = (g[0] & g[1]) | (g[2] & g[3]);
			end
			cell_cfg_pkg::FN_OR_XOR: begin
				funcComb = (g[0] | g[1]) ^ (g[2] | g[3]);
			end
			cell_cfg_pkg::FN_AND4: begin
				funcComb = &g;
			end
			default: begin
				funcComb = state_r;
			end
		endcase
	end

	// Stored functions; set and reset act as levels, reset winning except in the set-reset latch, where set wins.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= cell_cfg_pkg::STATE_RST;
		end else if (!enable_r) begin
			state_r <= cell_cfg_pkg::STATE_RST;
		end else begin
			case (mode)
				cell_cfg_pkg::FN_SR_LATCH: begin
					if (g[0] | g[1]) begin
						state_r <= 1'b1;
					end else if (g[2] | g[3]) begin
						state_r <= 1'b0;
					end
				end
				cell_cfg_pkg::FN_DFF_SR: begin
					if (g[2]) begin
						state_r <= 1'b0;
					end else if (g[3]) begin
						state_r <= 1'b1;
					end else if (clkRise) begin
						state_r <= g[1];
					end
				end
				cell_cfg_pkg::FN_DFF2_R: begin
					if (g[2]) begin
						state_r <= 1'b0;
					end else if (clkRise) begin
						state_r <= g[1] & g[3];
					end
				end
				cell_cfg_pkg::FN_JK_R: begin
					if (g[2]) begin
						state_r <= 1'b0;
					end else if (clkRise) begin
						state_r <= (g[1] & ~state_r) | (~g[3] & state_r);
					end
				end
				cell_cfg_pkg::FN_LATCH_SR: begin
					if (g[2]) begin
						state_r <= 1'b0;
					end else if (g[3]) begin
						state_r <= 1'b1;
					end else if (g[0]) begin
						state_r <= g[1];
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// Previous gate 1 level for the flop clock edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clkPrev_r <= 1'b0;
		end else begin
			clkPrev_r <= g[0];
		end
	end

	// Output inversion comes last; a disabled cell drives zero.
	assign cellNxt = enable_r & (funcComb ^ resInv_r);

	// Cell output, pin data and pin enable all come from flops.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cellOut_r  <= 1'b0;
			pinOut_r   <= 1'b0;
			pinOeOut_r <= 1'b0;
		end else begin
			cellOut_r  <= cellNxt;
			pinOut_r   <= cellNxt;
			pinOeOut_r <= pinOe_r;
		end
	end

	// Edges of the registered output, so each transition is seen once.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prevOut_r <= 1'b0;
		end else begin
			prevOut_r <= cellOut_r;
		end
	end

	// An invert change shows up as a plain output edge here.
	assign edgeHit = (riseEn_r & cellOut_r & ~prevOut_r)
		| (fallEn_r & ~cellOut_r & prevOut_r);

	// Write one to the status bit clears the flag.
	assign flagClr = wrTake && address == cell_cfg_pkg::OFS_STATUS
		&& writedata[cell_cfg_pkg::BIT_IRQ_FLAG];

	// A new edge wins over a clear in the same cycle.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqFlag_r <= 1'b0;
		end else if (edgeHit) begin
			irqFlag_r <= 1'b1;
		end else if (flagClr) begin
			irqFlag_r <= 1'b0;
		end
	end

	assign readdata    = readData_r;
	assign waitrequest = waitReq_r;
	assign cellOut     = cellOut_r;
	assign pinOut      = pinOut_r;
	assign pinOe       = pinOeOut_r;
	assign irqFlag     = irqFlag_r;
endmodule : logic_cell_config_regs

// ---- cell_cfg_pkg.sv ----
// Offsets, field positions, reset values and function codes of the logic cell.
package cell_cfg_pkg;
	localparam int          ADDR_W        = 6;
	localparam int          SRC_N         = 16;
	localparam int          GATE_N        = 4;
	// Register byte offsets; gate n select sits at OFS_GATE_BASE + 4*n.
	localparam logic [5:0]  OFS_CONTROL   = 6'h00;
	localparam logic [5:0]  OFS_POLARITY  = 6'h04;
	localparam logic [5:0]  OFS_SEL_LOW   = 6'h08;
	localparam logic [5:0]  OFS_SEL_HIGH  = 6'h0c;
	localparam logic [5:0]  OFS_GATE_BASE = 6'h10;
	localparam logic [5:0]  OFS_STATUS    = 6'h20;
	// Control fields.
	localparam int          BIT_ENABLE    = 7;
	localparam int          BIT_PIN_OE    = 6;
	localparam int          BIT_VIEW      = 5;
	localparam int          BIT_RISE_EN   = 4;
	localparam int          BIT_FALL_EN   = 3;
	localparam int          MODE_LSB      = 0;
	// Polarity, select and status fields.
	localparam int          BIT_RES_INV   = 7;
	localparam int          GINV_LSB      = 0;
	localparam int          SEL_LO_LSB    = 0;
	localparam int          SEL_HI_LSB    = 4;
	localparam int          BIT_IRQ_FLAG  = 0;
	// Values after reset.
	localparam logic [7:0]  CONTROL_RST   = 8'h00;
	localparam logic        RES_INV_RST   = 1'b0;
	localparam logic        STATE_RST     = 1'b0;
	localparam logic [15:0] SYNC_RST      = 16'h0000;
	// Source pool offsets of the four data selectors.
	localparam logic [3:0]  D1_BASE       = 4'h0;
	localparam logic [3:0]  D2_BASE       = 4'h4;
	localparam logic [3:0]  D3_BASE       = 4'h8;
	localparam logic [3:0]  D4_BASE       = 4'hc;
	typedef enum logic [2:0] {
		FN_AND_OR, FN_OR_XOR, FN_AND4, FN_SR_LATCH,
		FN_DFF_SR, FN_DFF2_R, FN_JK_R, FN_LATCH_SR
	} cell_func_t;
endpackage : cell_cfg_pkg

// ---- cell_path_if.sv ----
// Carrier between the cell core, the input synchroniser and the data gates.
`timescale 1ns/10ps
interface cell_path_if;
	logic [15:0] srcSync;
	wire logic [3:0] dataIn;
	logic [7:0]  gateSel [4];
	logic [3:0]  gateInv;
	wire logic [3:0] gateOut;
	modport sync (output srcSync);
	modport gate (input dataIn, input gateSel, input gateInv, output gateOut);
	modport core (input srcSync, input gateOut, output dataIn, output gateSel, output gateInv);
endinterface : cell_path_if

// ---- input_sync.sv ----
// Three-stage synchroniser with agreement filter for the source pool.
`timescale 1ns/10ps
module input_sync (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] rawIn,
	cell_path_if.sync        path
);
	logic [15:0] stage1_r;
	logic [15:0] stage2_r;
	logic [15:0] stage3_r;
	logic [15:0] stable_r;
	logic [15:0] agree;

	// Only stage2 reads stage1, so a metastable first stage cannot leak.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_r <= cell_cfg_pkg::SYNC_RST;
			stage2_r <= cell_cfg_pkg::SYNC_RST;
			stage3_r <= cell_cfg_pkg::SYNC_RST;
		end else begin
			stage1_r <= rawIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// A bit changes only once stages two and three agree on it.
	assign agree = ~(stage2_r ^ stage3_r);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stable_r <= cell_cfg_pkg::SYNC_RST;
		end else begin
			stable_r <= (stage3_r & agree) | (stable_r & ~agree);
		end
	end

	assign path.srcSync = stable_r;
endmodule : input_sync

// ---- data_gate.sv ----
// One data gate: AND of the enabled true or negated data inputs, then optional inversion.
`timescale 1ns/10ps
module data_gate #(
	parameter int IDX = 0
) (
	cell_path_if.gate path
);
	logic andHit;
	logic anyOn;

	// Bit 2k+1 gates data k true, bit 2k gates it negated; none enabled gives zero.
	always_comb begin
		andHit = 1'b1;
		anyOn  = 1'b0;
		for (int k = 0; k < 4; k++) begin
			if (path.gateSel[IDX][2*k+1]) begin
				anyOn  = 1'b1;
				andHit = andHit & path.dataIn[k];
			end
			if (path.gateSel[IDX][2*k]) begin
				anyOn  = 1'b1;
				andHit = andHit & ~path.dataIn[k];
			end
		end
	end

	// Gate polarity applies after the AND, so an empty gate can read as one.
	assign path.gateOut[IDX] = (anyOn & andHit) ^ path.gateInv[IDX];
endmodule : data_gate

// ---- logic_cell_chk.sv ----
// Port-level assertions for the logic cell register bank.
`timescale 1ns/10ps
module logic_cell_chk (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic [5:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [15:0] srcIn,
	input wire logic        cellOut,
	input wire logic        pinOut,
	input wire logic        pinOe,
	input wire logic        irqFlag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Every request is answered on the next edge, and the answer lasts one cycle only.
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered in one cycle");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_read_stands: assert property ($changed(readdata) |-> $fell(waitrequest) && $past(read))
		else $error("read data moved outside a read");
	// The pin carries the cell result; its enable only moves after a register write.
	a_pin_mirror: assert property (pinOut == cellOut)
		else $error("pin data differs from cell output");
	a_oe_from_write: assert property ($changed(pinOe) |-> $past(write) || $past(write, 2))
		else $error("pin enable moved without a write");
	// The flag is set only by a synchronised output edge and drops only on a write.
	a_flag_cause: assert property ($rose(irqFlag) |-> $past(cellOut) != $past(cellOut, 2))
		else $error("flag set without an output edge");
	a_flag_sticky: assert property (irqFlag && !write |=> irqFlag)
		else $error("flag cleared without a write");

	c_flag_set: cover property ($rose(irqFlag));
	c_flag_clear: cover property ($fell(irqFlag));
	c_oe_on: cover property ($rose(pinOe));
endmodule : logic_cell_chk

bind logic_cell_config_regs logic_cell_chk i_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .srcIn(srcIn), .cellOut(cellOut), .pinOut(pinOut),
	.pinOe(pinOe), .irqFlag(irqFlag)
);

// ---- tb_top.sv ----
// Self-checking bench for the logic cell register bank.
`timescale 1ns/10ps
module tb_top;
	localparam logic [5:0] CTRL = cell_cfg_pkg::OFS_CONTROL;
	localparam logic [5:0] POL  = cell_cfg_pkg::OFS_POLARITY;
	localparam logic [5:0] SLO  = cell_cfg_pkg::OFS_SEL_LOW;
	localparam logic [5:0] SHI  = cell_cfg_pkg::OFS_SEL_HIGH;
	localparam logic [5:0] STAT = cell_cfg_pkg::OFS_STATUS;
	logic        sys_clk;
	logic        arst_n;
	logic [5:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [15:0] srcIn;
	logic        cellOut;
	logic        pinOut;
	logic        pinOe;
	logic        irqFlag;
	int          mismatches;
	int          cmp_count;
	logic [7:0]  q;
	logic [3:0]  g;
	logic [2:0]  md;
	logic        e;
	// Sequential steps: gates in [7:4], expected output in [3], function code in [2:0].
	logic [7:0]  steps [38] = '{8'h1b, 8'h0b, 8'h43, 8'h03, 8'h5b, 8'h44, 8'h04, 8'h24,
		8'h3c, 8'h1c, 8'h0c, 8'h14, 8'h8c, 8'hc4, 8'h45, 8'h05, 8'h25, 8'h35, 8'h05, 8'ha5,
		8'hbd, 8'hf5, 8'h46, 8'h06, 8'h26, 8'h3e, 8'h2e, 8'hb6, 8'ha6, 8'hbe, 8'h8e, 8'h96,
		8'h47, 8'h07, 8'h3f, 8'h17, 8'h27, 8'h8f};

	logic_cell_config_regs i_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .srcIn(srcIn), .cellOut(cellOut), .pinOut(pinOut),
		.pinOe(pinOe), .irqFlag(irqFlag)
	);

	// Free-running system clock.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		$display("mismatches %0d of %0d compares", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One bus transfer; the request is held until waitrequest is sampled low.
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		address   <= a;
		read      <= ~wr;
		write     <= wr;
		writedata <= {24'h0, d};
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (waitrequest === 1'b0) break;
		end
		if (n == 20) begin
			mismatches++;
			complete_run();
		end
		q = readdata[7:0];
		read  <= 1'b0;
		write <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rd

	// Puts gate pattern onto sources 0, 4, 8, 12 and waits out the synchroniser.
	task automatic drive(input logic [3:0] v);
		srcIn <= {3'h0, v[3], 3'h0, v[2], 3'h0, v[1], 3'h0, v[0]};
		repeat (8) @(posedge sys_clk);
	endtask : drive

	// Main sequence.
	initial begin
		arst_n = 1'b0;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h1;
		srcIn = 16'h0;
		mismatches = 0;
		cmp_count = 0;
		md = 3'h0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(CTRL, 8'h00);
		xfer(1'b0, POL, 8'h00);
		chk(q & 8'h80, 8'h00);
		rd(6'h3c, 8'h00);
		wr(POL, 8'hff);
		rd(POL, 8'h8f);
		wr(SLO, 8'hff);
		rd(SLO, 8'h77);
		wr(SHI, 8'hff);
		rd(SHI, 8'h77);
		wr(POL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(cell_cfg_pkg::OFS_GATE_BASE + 6'(4 * k), 8'h02 << (2 * k));
		end
		// A one-hot source must reach exactly one gate of the OR-XOR for every code.
		wr(CTRL, 8'h81);
		for (int c = 0; c < 8; c++) begin
			wr(SLO, {1'b0, 3'(c), 1'b0, 3'(c)});
			wr(SHI, {1'b0, 3'(c), 1'b0, 3'(c)});
			for (int k = 0; k < 4; k++) begin
				srcIn <= 16'h1 << (4'(c) + 4'(4 * k));
				repeat (8) @(posedge sys_clk);
				chk(8'(cellOut), 8'h01);
			end
		end
		wr(SLO, 8'h00);
		wr(SHI, 8'h00);
		for (int m = 0; m < 3; m++) begin
			wr(CTRL, 8'h80 | 8'(m));
			for (int v = 0; v < 16; v++) begin
				g = 4'(v);
				drive(g);
				e = m == 0 ? (g[0] & g[1]) | (g[2] & g[3]) : m == 1 ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g;
				chk(8'(cellOut), 8'(e));
			end
		end
		for (int s = 0; s < 38; s++) begin
			if (steps[s][2:0] != md) begin
				md = steps[s][2:0];
				wr(CTRL, {5'h10, md});
			end
			drive(steps[s][7:4]);
			chk(8'(cellOut), 8'(steps[s][3]));
		end
		chk(8'(irqFlag), 8'h00);
		wr(CTRL, 8'h07);
		drive(4'h8);
		chk(8'(cellOut), 8'h00);
		// Edge interrupts, driven by flipping the result inversion of a quiet AND.
		drive(4'h0);
		wr(CTRL, 8'h92);
		wr(POL, 8'h80);
		drive(4'h0);
		chk(8'(cellOut), 8'h01);
		chk(8'(irqFlag), 8'h01);
		rd(CTRL, 8'hb2);
		chk(8'(pinOe), 8'h00);
		wr(STAT, 8'h01);
		drive(4'h0);
		chk(8'(irqFlag), 8'h00);
		wr(POL, 8'h00);
		drive(4'h0);
		chk(8'(irqFlag), 8'h00);
		wr(CTRL, 8'hea);
		rd(CTRL, 8'hca);
		chk(8'(pinOe), 8'h01);
		wr(POL, 8'h80);
		drive(4'h0);
		chk(8'(irqFlag), 8'h00);
		wr(POL, 8'h00);
		drive(4'h0);
		chk(8'(irqFlag), 8'h01);
		rd(STAT, 8'h01);
		wr(POL, 8'h0f);
		drive(4'h0);
		chk(8'(cellOut), 8'h01);
		chk(8'(pinOut), 8'h01);
		// Gate 1 first takes data 1 negated, then nothing, which must read as zero.
		wr(cell_cfg_pkg::OFS_GATE_BASE, 8'h01);
		wr(POL, 8'h0e);
		drive(4'h0);
		chk(8'(cellOut), 8'h01);
		wr(cell_cfg_pkg::OFS_GATE_BASE, 8'h00);
		drive(4'h0);
		chk(8'(cellOut), 8'h00);
		// A later reset clears control and result inversion but keeps the selections.
		wr(SLO, 8'h35);
		wr(POL, 8'h85);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(CTRL, 8'h00);
		rd(POL, 8'h05);
		rd(SLO, 8'h35);
		chk(8'(pinOe), 8'h00);
		complete_run();
	end
endmodule : tb_top
